//--- css_peer.sv
// Far side: pulled-up init and done wires, a peer holding them, loop locks.
// Assumes the bench commands the holds and the lock state.
`timescale 1ns/1ns
module css_peer (
  input  wire logic       init_oe,
  input  wire logic       done_oe,
  input  wire logic       hold_init,
  input  wire logic       hold_done,
  input  wire logic       lock_go,
  output logic            init_w,
  output logic            done_w,
  output logic [7:0]      lock
);
  // Pull-ups: any party driving low wins
  assign init_w = !(init_oe || hold_init);
  assign done_w = !(done_oe || hold_done);
  assign lock   = {8{lock_go}};
endmodule // css_peer

//--- css_pkg.sv
// Package for the configuration start-up sequencer: states, timing, layout.
// Assumes a single 25 MHz core clock and the CSS register port.
package css_pkg;

  localparam int unsigned CLK_MHZ          = 25;
  localparam real         POR_MS           = 2.0;
  localparam int unsigned POR_CYCLES       = int'(POR_MS * 1000.0) * CLK_MHZ;
  localparam int unsigned CLEAR_CYCLES     = 64;
  localparam int unsigned LOAD_CYCLES      = 32;
  localparam int unsigned NUM_LOOPS        = 8;

  // Register addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STEPS   = 8'h04;
  localparam logic [7:0] ADDR_LOCKSEL = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_RDBK    = 8'h1C;

  // Control bit positions
  localparam int unsigned CTRL_PROG     = 0;
  localparam int unsigned CTRL_SYNC     = 1;
  localparam int unsigned CTRL_HOLDLOCK = 2;

  // Reset values
  localparam logic [2:0]  CTRL_RST    = 3'h0;
  localparam logic [11:0] STEPS_RST   = 12'h221;  // od=1, preset=2, write=2
  localparam logic [15:0] LOCKSEL_RST = 16'h0000;
  localparam logic [31:0] RDBK_RST    = 32'h0000_0000;

  localparam int unsigned IRQ_INIT = 0;
  localparam int unsigned IRQ_DONE = 1;
  localparam int unsigned IRQ_UP   = 2;
  localparam int unsigned IRQ_W    = 3;

  typedef enum logic [2:0] {
    CSS_POR   = 3'b000,
    CSS_CLEAR = 3'b001,
    CSS_HOLD  = 3'b010,
    CSS_LOAD  = 3'b011,
    CSS_DONE  = 3'b100,
    CSS_STEP  = 3'b101,
    CSS_RUN   = 3'b110
  } css_state_e;

  // Start-up step positions, counted in config clock cycles after done
  typedef struct packed {
    logic [3:0] write_pos;
    logic [3:0] preset_pos;
    logic [3:0] od_pos;
  } css_steps_s;

  // Lock wait settings: which loops, and whether all or any must lock
  typedef struct packed {
    logic [3:0]  stage;
    logic [NUM_LOOPS-1:0] mask;
    logic [3:0]  mode_all;
  } css_locksel_s;

endpackage

//--- css_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes inputs may change at any time relative to CLK.
`timescale 1ns/1ns
module css_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             CLK,
  input  wire logic             RSTN,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // css_sync

//--- css_top.sv
// Configuration start-up sequencer: clear, load, start-up release.
// Assumes CLK is the config clock; pins INIT, DONE, program and lock are
// asynchronous and are synchronised here.
`timescale 1ns/1ns

module css_top #(
  parameter int unsigned POR_CNT = css_pkg::POR_CYCLES,
  parameter int unsigned NLOOP   = css_pkg::NUM_LOOPS
) (
  input  wire logic             CLK,
  input  wire logic             RSTN,
  input  wire logic [7:0]       ADDR,
  input  wire logic [31:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [31:0]      RDATA,
  input  wire logic             PROGRAM_N,
  input  wire logic             INIT_IN,
  output logic                  INIT_OUT,
  output logic                  INIT_OE,
  input  wire logic             DONE_IN,
  output logic                  DONE_OUT,
  output logic                  DONE_OE,
  input  wire logic [NLOOP-1:0] LOCK,
  output logic                  GLOBAL_OUTPUT_DISABLE,
  output logic                  GLOBAL_PRESET,
  output logic                  GLOBAL_WRITE_GATE,
  output logic                  IRQ
);

  // Lock select layout is sized by the package, so the loop count is fixed
  if (NLOOP != css_pkg::NUM_LOOPS || POR_CNT < 1) begin : g_param_check
    $error("css_top: unsupported parameter values");
  end

  // Synchronised pins
  logic [NLOOP+2:0] pins_s;
  logic             prog_req;
  logic             init_pin;
  logic             done_pin;
  logic [NLOOP-1:0] lock_s;

  css_sync #(
    .WIDTH(NLOOP + 3)
  ) u_sync (
    .CLK (CLK),
    .RSTN(RSTN),
    .d   ({LOCK, DONE_IN, INIT_IN, ~PROGRAM_N}),
    .q   (pins_s)
  );
  assign prog_req = pins_s[0];
  assign init_pin = pins_s[1];
  assign done_pin = pins_s[2];
  assign lock_s   = pins_s[NLOOP+2:3];

  // Registers
  logic [2:0]                ctrl, next_ctrl;
  css_pkg::css_steps_s       steps, next_steps;
  css_pkg::css_locksel_s     locksel, next_locksel;
  logic [css_pkg::IRQ_W-1:0] irq_st, next_irq_st;
  logic [css_pkg::IRQ_W-1:0] irq_en, next_irq_en;
  logic [31:0]               rdata, next_rdata;

  // Sequencer
  css_pkg::css_state_e state, next_state;
  logic [31:0]         cnt, next_cnt;
  logic [3:0]          step, next_step;
  logic                od, next_od;
  logic                pre, next_pre;
  logic                wg, next_wg;
  logic                done_drv, next_done_drv;
  // Registered copy of the done pull, so the pin enable leaves a flop
  logic                done_pull, next_done_pull;
  logic                init_low, next_init_low;
  logic                irq, next_irq;
  logic [31:0]         rdbk, next_rdbk;

  function automatic logic locks_ok(
    input logic [NLOOP-1:0] mask,
    input logic             all,
    input logic [NLOOP-1:0] lk
  );
    logic ok;
    ok = 1'b1;
    if (mask != '0) begin
      if (all)
        ok = ((lk & mask) == mask);
      else
        ok = ((lk & mask) != '0);
    end
    return ok;
  endfunction

  logic lock_gate;
  logic sync_ok;
  logic ev_init;
  logic ev_done;
  logic ev_up;

  always_comb begin
    lock_gate = locks_ok(locksel.mask, locksel.mode_all[0], lock_s);
    sync_ok   = !ctrl[css_pkg::CTRL_SYNC] || done_pin;
    next_state    = state;
    next_cnt      = cnt;
    next_step     = step;
    next_od       = od;
    next_pre      = pre;
    next_wg       = wg;
    next_done_drv = done_drv;
    next_init_low = init_low;
    next_rdbk     = rdbk;
    ev_init       = 1'b0;
    ev_done       = 1'b0;
    ev_up         = 1'b0;
    if (prog_req || ctrl[css_pkg::CTRL_PROG]) begin
      next_state    = css_pkg::CSS_CLEAR;
      next_cnt      = '0;
      next_step     = '0;
      next_od       = 1'b1;
      next_pre      = 1'b1;
      next_wg       = 1'b1;
      next_done_drv = 1'b0;
      next_init_low = 1'b1;
    end else begin
      case (state)
        css_pkg::CSS_POR: begin
          // Power-on wait bounded by the count
          if (cnt >= 32'(POR_CNT - 1)) begin
            next_state = css_pkg::CSS_CLEAR;
            next_cnt   = '0;
          end else begin
            next_cnt = cnt + 32'h0000_0001;
          end
        end
        css_pkg::CSS_CLEAR: begin
          next_init_low = 1'b1;
          if (cnt >= 32'(css_pkg::CLEAR_CYCLES - 1)) begin
            next_state    = css_pkg::CSS_HOLD;
            next_init_low = 1'b0;
            next_cnt      = '0;
            ev_init       = 1'b1;
          end else begin
            next_cnt = cnt + 32'h0000_0001;
          end
        end
        css_pkg::CSS_HOLD: begin
          // Outside party holds init low to delay loading
          if (init_pin)
            next_state = css_pkg::CSS_LOAD;
        end
        css_pkg::CSS_LOAD: begin
          if (cnt >= 32'(css_pkg::LOAD_CYCLES - 1)) begin
            // A failed lock check reruns the load count before retrying
            next_cnt = '0;
            // Completion held until lock when enabled
            if (!ctrl[css_pkg::CTRL_HOLDLOCK] || lock_gate) begin
              next_state    = css_pkg::CSS_DONE;
              next_done_drv = 1'b1;
              ev_done       = 1'b1;
            end
          end else begin
            next_cnt = cnt + 32'h0000_0001;
          end
        end
        css_pkg::CSS_DONE, css_pkg::CSS_STEP: begin
          // Each step counts one clock after done; stalls on gates
          if (sync_ok && (step != locksel.stage || lock_gate)) begin
            next_step  = step + 4'h1;
            next_state = css_pkg::CSS_STEP;
            if (next_step >= steps.od_pos)
              next_od = 1'b0;
            if (next_step >= steps.preset_pos)
              next_pre = 1'b0;
            if (next_step >= steps.write_pos)
              next_wg = 1'b0;
            if (!next_od && !next_pre && !next_wg) begin
              next_state = css_pkg::CSS_RUN;
              ev_up      = 1'b1;
            end
          end
        end
        css_pkg::CSS_RUN: begin
          // Snapshot of loaded state for readback
          next_rdbk = {16'h0000, 8'(cnt), 4'h0, steps.od_pos};
        end
        default: next_state = css_pkg::CSS_POR;
      endcase
    end
  end

  always_comb begin
    next_ctrl    = ctrl;
    next_ctrl[css_pkg::CTRL_PROG] = 1'b0;
    next_steps   = steps;
    next_locksel = locksel;
    next_irq_en  = irq_en;
    next_irq_st  = irq_st;
    next_rdata   = 32'h0000_0000;
    if (WR) begin
      if (ADDR == css_pkg::ADDR_CTRL)
        next_ctrl = WDATA[2:0];
      else if (ADDR == css_pkg::ADDR_STEPS)
        next_steps = WDATA[11:0];
      else if (ADDR == css_pkg::ADDR_LOCKSEL)
        next_locksel = WDATA[15:0];
      else if (ADDR == css_pkg::ADDR_IRQ_EN)
        next_irq_en = WDATA[css_pkg::IRQ_W-1:0];
      else if (ADDR == css_pkg::ADDR_IRQ_CLR)
        next_irq_st = irq_st & ~WDATA[css_pkg::IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    next_irq_st = next_irq_st | {ev_up, ev_done, ev_init};
    if (RD) begin
      if (ADDR == css_pkg::ADDR_CTRL)
        next_rdata = {29'h0, ctrl};
      else if (ADDR == css_pkg::ADDR_STEPS)
        next_rdata = {20'h0_0000, steps};
      else if (ADDR == css_pkg::ADDR_LOCKSEL)
        next_rdata = {16'h0000, locksel};
      else if (ADDR == css_pkg::ADDR_STATUS)
        next_rdata = {15'h0000, lock_s, init_pin, done_pin, wg, pre, od,
                      done_drv, state};
      else if (ADDR == css_pkg::ADDR_IRQ_ST)
        next_rdata = {29'h0, irq_st};
      else if (ADDR == css_pkg::ADDR_IRQ_EN)
        next_rdata = {29'h0, irq_en};
      else if (ADDR == css_pkg::ADDR_RDBK)
        next_rdata = rdbk;
    end
    next_irq = |(next_irq_st & next_irq_en);
    next_done_pull = !next_done_drv;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state    <= css_pkg::CSS_POR;
      cnt      <= '0;
      step     <= '0;
      od       <= 1'b1;
      pre      <= 1'b1;
      wg       <= 1'b1;
      done_drv <= 1'b0;
      done_pull <= 1'b1;
      init_low <= 1'b1;
      rdbk     <= css_pkg::RDBK_RST;
      ctrl     <= css_pkg::CTRL_RST;
      steps    <= css_pkg::STEPS_RST;
      locksel  <= css_pkg::LOCKSEL_RST;
      irq_st   <= '0;
      irq_en   <= '0;
      rdata    <= 32'h0000_0000;
      irq      <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      step     <= next_step;
      od       <= next_od;
      pre      <= next_pre;
      wg       <= next_wg;
      done_drv <= next_done_drv;
      done_pull <= next_done_pull;
      init_low <= next_init_low;
      rdbk     <= next_rdbk;
      ctrl     <= next_ctrl;
      steps    <= next_steps;
      locksel  <= next_locksel;
      irq_st   <= next_irq_st;
      irq_en   <= next_irq_en;
      rdata    <= next_rdata;
      irq      <= next_irq;
    end
  end

  // Open-drain pins: output level always low, enable when pulling
  always_comb begin
    RDATA                 = rdata;
    INIT_OUT              = 1'b0;
    INIT_OE               = init_low;
    DONE_OUT              = 1'b0;
    DONE_OE               = done_pull;
    GLOBAL_OUTPUT_DISABLE = od;
    GLOBAL_PRESET         = pre;
    GLOBAL_WRITE_GATE     = wg;
    IRQ                   = irq;
  end

endmodule // css_top

//--- css_top_checker.sv
// Pin-level checks for the start-up sequencer, bound to css_top.
// Assumes one clock CLK and the asynchronous active-low RSTN.
`timescale 1ns/1ns
module css_top_checker (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        PROGRAM_N,
  input wire logic        INIT_IN,
  input wire logic        INIT_OUT,
  input wire logic        INIT_OE,
  input wire logic        DONE_OUT,
  input wire logic        DONE_OE,
  input wire logic        GLOBAL_OUTPUT_DISABLE,
  input wire logic        GLOBAL_PRESET,
  input wire logic        GLOBAL_WRITE_GATE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // Two samples low, so a one-cycle glitch is not taken as a request
  sequence s_prog_low;
    !PROGRAM_N ##1 !PROGRAM_N;
  endsequence
  sequence s_all_driven;
    DONE_OE && INIT_OE && GLOBAL_OUTPUT_DISABLE && GLOBAL_PRESET
      && GLOBAL_WRITE_GATE;
  endsequence

  a_prog_restart:
    assert property (s_prog_low |-> ##[1:4] s_all_driven)
    else $error("Program request did not restart the sequence");
  a_release_after_done:
    assert property (($fell(GLOBAL_OUTPUT_DISABLE) || $fell(GLOBAL_PRESET)
      || $fell(GLOBAL_WRITE_GATE)) |-> !DONE_OE)
    else $error("Global released before done");
  a_globals_held:
    assert property (DONE_OE [*4] |-> GLOBAL_OUTPUT_DISABLE && GLOBAL_PRESET
      && GLOBAL_WRITE_GATE)
    else $error("Global released while done is driven low");
  a_init_clear_low:
    assert property ($rose(INIT_OE) |=> INIT_OE [*8])
    else $error("Init released too early in clearing");
  a_hold_no_load:
    assert property (!INIT_IN && DONE_OE |=> DONE_OE)
    else $error("Done finished while init held low");
  a_done_after_init:
    assert property ($fell(DONE_OE) |-> !INIT_OE && INIT_IN)
    else $error("Done before init released");
  a_open_drain_low:
    assert property (INIT_OUT == 1'b0 && DONE_OUT == 1'b0)
    else $error("Open-drain pin driven high");
  a_rdata_quiet:
    assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("Read data outside read answer cycle");
endmodule // css_top_checker

bind css_top css_top_checker chk_u (
  .CLK(CLK), .RSTN(RSTN), .RD(RD), .RDATA(RDATA), .PROGRAM_N(PROGRAM_N),
  .INIT_IN(INIT_IN), .INIT_OUT(INIT_OUT), .INIT_OE(INIT_OE),
  .DONE_OUT(DONE_OUT), .DONE_OE(DONE_OE),
  .GLOBAL_OUTPUT_DISABLE(GLOBAL_OUTPUT_DISABLE),
  .GLOBAL_PRESET(GLOBAL_PRESET), .GLOBAL_WRITE_GATE(GLOBAL_WRITE_GATE)
);

//--- css_top_tb_top.sv
// Self-checking bench for css_top with a pulled-up far-side model.
// Assumes css_pkg, css_top, css_peer and the bound checker are compiled.
`timescale 1ns/1ns
module css_top_tb_top;
  logic        CLK, RSTN, WR, RD, PROGRAM_N, IRQ;
  logic        INIT_IN, INIT_OUT, INIT_OE, DONE_IN, DONE_OUT, DONE_OE;
  logic        god, gpr, gwg, hold_init, hold_done, lock_go;
  logic [7:0]  ADDR, LOCK;
  logic [31:0] WDATA, RDATA, d;
  int          num_errors, samples_checked, cyc, n;
  int          t_done, t_od, t_pr, t_wg, od, pr, wg;

  css_top #(.POR_CNT(20)) dut_u (
    .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PROGRAM_N(PROGRAM_N), .INIT_IN(INIT_IN),
    .INIT_OUT(INIT_OUT), .INIT_OE(INIT_OE), .DONE_IN(DONE_IN),
    .DONE_OUT(DONE_OUT), .DONE_OE(DONE_OE), .LOCK(LOCK),
    .GLOBAL_OUTPUT_DISABLE(god), .GLOBAL_PRESET(gpr),
    .GLOBAL_WRITE_GATE(gwg), .IRQ(IRQ));
  css_peer peer_u (
    .init_oe(INIT_OE), .done_oe(DONE_OE), .hold_init(hold_init),
    .hold_done(hold_done), .lock_go(lock_go), .init_w(INIT_IN),
    .done_w(DONE_IN), .lock(LOCK));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // Release moments, in cycles, for the start-up order model
  always @(posedge CLK) cyc++;
  always @(negedge DONE_OE) t_done = cyc;
  always @(negedge god) t_od = cyc;
  always @(negedge gpr) t_pr = cyc;
  always @(negedge gwg) t_wg = cyc;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= v;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask
  // Peer holds init low through clearing and a random stretch after it
  task automatic boot(input logic e);
    hold_init <= 1'b1;
    repeat (5) @(posedge CLK);
    for (n = 0; INIT_OE !== 1'b0 && n < 400; n++) @(posedge CLK);
    chk("init_bound", 1, n <= 90);
    repeat ($urandom_range(2, 20)) @(posedge CLK);
    #1 chk("done_held", 1, DONE_OE);
    @(posedge CLK);
    hold_init <= 1'b0;
    for (n = 0; DONE_OE !== 1'b0 && n < 60; n++) @(posedge CLK);
    #1 chk("done_drive", !e, DONE_OE);
    repeat (24) @(posedge CLK);
  endtask
  task automatic steps_chk();
    chk("od_after_done", od, t_od - t_done);
    chk("preset_after_od", pr - od, t_pr - t_od);
    chk("write_after_od", wg - od, t_wg - t_od);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge CLK);
    num_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(47287));
    {RSTN, WR, RD, ADDR, WDATA, hold_done, lock_go} = '0;
    {PROGRAM_N, hold_init} = 2'b11;
    {num_errors, samples_checked} = '0;
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    #1 chk("globals_reset", 3'h7, {god, gpr, gwg});
    rd(css_pkg::ADDR_STEPS);
    chk("steps_reset", css_pkg::STEPS_RST, d[11:0]);
    {od, pr, wg} = {32'd1, 32'd2, 32'd2};
    wr(css_pkg::ADDR_STEPS, 32'h0000_0221);
    boot(1'b1);
    steps_chk();
    $display("power-up start done");
    od = $urandom_range(1, 3);
    pr = od + $urandom_range(1, 3);
    wg = pr + $urandom_range(0, 2);
    wr(css_pkg::ADDR_STEPS, 32'({wg[3:0], pr[3:0], od[3:0]}));
    wr(css_pkg::ADDR_CTRL, 32'h0000_0001);
    boot(1'b1);
    steps_chk();
    $display("software restart with new positions done");
    @(posedge CLK);
    PROGRAM_N <= 1'b0;
    repeat (5) @(posedge CLK);
    PROGRAM_N <= 1'b1;
    #1 chk("pin_restart", 4'hF, {god, gpr, gwg, DONE_OE});
    boot(1'b1);
    steps_chk();
    $display("pin restart done");
    hold_done <= 1'b1;
    wr(css_pkg::ADDR_CTRL, 32'h0000_0003);
    boot(1'b1);
    chk("wait_shared_done", 1, god);
    hold_done <= 1'b0;
    repeat (16) @(posedge CLK);
    chk("shared_done_go", 3'h0, {god, gpr, gwg});
    $display("shared done wait done");
    wr(css_pkg::ADDR_LOCKSEL, 32'h0000_0ff1);
    wr(css_pkg::ADDR_CTRL, 32'h0000_0005);
    boot(1'b0);
    lock_go <= 1'b1;
    for (n = 0; DONE_OE !== 1'b0 && n < 40; n++) @(posedge CLK);
    repeat (24) @(posedge CLK);
    chk("lock_go", 4'h0, {god, gpr, gwg, DONE_OE});
    rd(css_pkg::ADDR_STATUS);
    chk("status", {15'h0000, 8'hFF, 2'b11, 3'h0, 1'b1, css_pkg::CSS_RUN},
        d);
    rd(css_pkg::ADDR_RDBK);
    chk("readback", od, d);
    $display("lock wait done");
    wr(css_pkg::ADDR_IRQ_EN, 32'h0000_0002);
    rd(css_pkg::ADDR_IRQ_ST);
    chk("irq_status", 3'h7, d[2:0]);
    chk("irq_level", 1, IRQ);
    wr(css_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
    rd(css_pkg::ADDR_IRQ_ST);
    chk("irq_cleared", 3'h0, d[2:0]);
    chk("irq_low", 0, IRQ);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC);
    chk("unmapped", 32'h0000_0000, d);
    $display("registers and interrupt done");
    stop_test();
  end
endmodule // css_top_tb_top
